// ==== core/clock_sleep_defs.svh ====
`ifndef CLOCK_SLEEP_DEFS_SVH
`define CLOCK_SLEEP_DEFS_SVH

// Register offsets on the plain register port
`define ADDR_OSC_TRIM        4'h0
`define ADDR_DIVIDE_CONTROL  4'h1
`define ADDR_CORE_CONTROL    4'h2
`define ADDR_SLEEP_STATUS    4'h3

// Field positions
`define UNLOCK_BIT           7
`define SELECT_MSB           3
`define SELECT_LSB           0
`define TRIM_RANGE_BIT       7
`define SLEEP_ALLOW_BIT      5
`define SLEEP_KIND_MSB       4
`define SLEEP_KIND_LSB       3

// Reset and special values
`define UNLOCK_WRITE_VALUE   8'h80
`define SELECT_RESET_PLAIN   4'h0
`define SELECT_RESET_DIV8    4'h3
`define SELECT_MAX_CODE      4'h8
`define SELECT_RESERVED_MASK 8'hff
`define TRIM_RESET           8'h00
`define READ_IDLE            8'h00

// Timing counts in clock cycles
`define UNLOCK_WINDOW_CYCLES 3'h4
`define WAKE_HALT_CYCLES     16'h0004
`define STANDBY_WAKE_CYCLES  16'h0006
`define STARTUP_DEFAULT      16'h0010

`endif

// ==== core/clock_sleep_pkg.sv ====
package clock_sleep_pkg;

    typedef enum logic [1:0] {
        SLEEP_IDLE      = 2'b00,
        SLEEP_NOISE_RED = 2'b01,
        SLEEP_POWERDOWN = 2'b10,
        SLEEP_STANDBY   = 2'b11
    } sleep_kind_t;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_STARTUP = 2'b10,
        ST_HALT    = 2'b11
    } power_state_t;

endpackage

// ==== core/divide_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface divide_link_if;
    logic [3:0] divideSelect;
    logic [3:0] activeSelect;
    logic       divTick;

    modport control (output divideSelect, input activeSelect, input divTick);
    modport divider (input divideSelect, output activeSelect, output divTick);
endinterface

`default_nettype wire

// ==== core/clock_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "clock_sleep_defs.svh"

module clock_divider
    import clock_sleep_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rstn,
    divide_link_if.divider link
);

    logic [7:0] count_q;
    logic [7:0] mask;
    logic [3:0] active_q;

    // Reserved codes run at the slowest rate rather than something faster
    always_comb begin
        if (active_q > `SELECT_MAX_CODE) begin
            mask = `SELECT_RESERVED_MASK;
        end else begin
            mask = 8'((9'h001 << active_q) - 9'h001);
        end
    end

    // New setting only loads at the end of a full old period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_q  <= 8'h00;
            active_q <= `SELECT_RESET_PLAIN;
        end else if (count_q == mask) begin
            count_q  <= 8'h00;
            active_q <= link.divideSelect;
        end else begin
            count_q <= count_q + 8'h01;
        end
    end

    assign link.divTick      = (count_q == mask);
    assign link.activeSelect = active_q;

endmodule

`default_nettype wire

// ==== core/clock_prescale_sleep_control.sv ====
// Notes on behaviour
// - Trim loads factory value on every reset
// - Trim top bit selects oscillator range
// - Low trim bits tune monotonically within range
// - Unlock set only with other bits zero
// - Unlock clears after four cycles or select write
// - Unlock rewrite neither extends nor clears window
// - Reserved divide bits read as zero
// - Select accepted only inside unlock window
// - Select resets per divide-by-eight fuse
// - Select accepts any value after reset
// - Select code gives power-of-two divisor
// - Sleep only when allowed; kind picks mode
// - Core halts four cycles beyond start-up
// - State kept in sleep; reset wakes
// - Idle stops core and flash clocks
// - Noise reduction limits wake sources
// - Power-down stops oscillator, few wake sources
// - External pin wakes deep modes only by level
// - Converter auto-starts on idle or noise entry
// - Standby keeps oscillator, wakes in six cycles; code does this only with crystalSource, else runs as power-down
// - Divide switch produces no glitch
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "clock_sleep_defs.svh"

module clock_prescale_sleep_control
    import clock_sleep_pkg::*;
#(
    parameter logic [15:0] STARTUP_CYCLES = `STARTUP_DEFAULT
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    // Register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    // Straps
    input  wire logic [7:0] factoryTrim,
    input  wire logic       divideByEightFuse,
    input  wire logic       crystalSource,
    // Core and peripheral events
    input  wire logic       sleepInstr,
    input  wire logic       converterEnabled,
    input  wire logic       anyIrq,
    input  wire logic       converterDoneIrq,
    input  wire logic       memoryReadyIrq,
    input  wire logic       externalLevelIrq,
    input  wire logic       externalEdgeIrq,
    input  wire logic       pinChangeIrq,
    input  wire logic       watchdogIrq,
    // Clock, trim, halt and wake/conversion pulse outputs
    output logic      [7:0] oscTrim,
    output logic            trimRangeSelect,
    output logic      [6:0] trimFine,
    output logic            sysClockTick,
    output logic      [3:0] activeDivide,
    output logic            coreClockRun,
    output logic            programMemoryClockRun,
    output logic            peripheralClockRun,
    output logic            converterClockRun,
    output logic            oscillatorRun,
    output logic            coreHalted,
    output logic            startConversion,
    output logic            resumeCore
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    divide_link_if link ();

    logic [7:0]   trim_q;
    logic [3:0]   select_q;
    logic [2:0]   unlockCnt_q;
    logic         unlockOpen;
    logic         sleepAllow_q;
    sleep_kind_t  sleepKind_q;
    sleep_kind_t  activeKind_q;
    power_state_t state_q;
    power_state_t state_d;
    logic [15:0]  waitCnt_q;
    logic [15:0]  waitCnt_d;
    logic         strapLoad_q;
    logic         startConv_q;
    logic         resume_q;
    logic [7:0]   rdata_q;
    logic         wrTrim;
    logic         wrDivide;
    logic         wrCore;
    logic         wakeEvent;
    logic         oscStopped;
    logic         sleepTaken;

    assign wrTrim   = regWrite && (regAddr == `ADDR_OSC_TRIM);
    assign wrDivide = regWrite && (regAddr == `ADDR_DIVIDE_CONTROL);
    assign wrCore   = regWrite && (regAddr == `ADDR_CORE_CONTROL);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture

    // Straps are ports, so they are caught one edge after release, not under reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strapLoad_q <= 1'b1;
        end else begin
            strapLoad_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator trim

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trim_q <= `TRIM_RESET;
        end else if (strapLoad_q) begin
            trim_q <= factoryTrim;
        end else if (wrTrim) begin
            trim_q <= regWdata;
        end
    end

    assign oscTrim         = trim_q;
    assign trimRangeSelect = trim_q[`TRIM_RANGE_BIT];
    assign trimFine        = trim_q[`TRIM_RANGE_BIT-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Divide unlock window

    assign unlockOpen = (unlockCnt_q != 3'h0);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            unlockCnt_q <= 3'h0;
        end else if (wrDivide && !regWdata[`UNLOCK_BIT] && unlockOpen) begin
            unlockCnt_q <= 3'h0;
        end else if (wrDivide && (regWdata == `UNLOCK_WRITE_VALUE) && !unlockOpen) begin
            unlockCnt_q <= `UNLOCK_WINDOW_CYCLES;
        end else if (unlockOpen) begin
            // A repeated unlock write lands here and does not restart
            unlockCnt_q <= unlockCnt_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divide select

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            select_q <= `SELECT_RESET_PLAIN;
        end else if (strapLoad_q) begin
            select_q <= divideByEightFuse ? `SELECT_RESET_DIV8
                                          : `SELECT_RESET_PLAIN;
        end else if (wrDivide && !regWdata[`UNLOCK_BIT] && unlockOpen) begin
            // Any code is stored, reserved ones included
            select_q <= regWdata[`SELECT_MSB:`SELECT_LSB];
        end
    end

    assign link.divideSelect = select_q;

    // Divider swaps setting only at period end, so no short pulse appears
    clock_divider u_divider (
        .clock (clock),
        .rstn  (rstn),
        .link  (link)
    );

    assign sysClockTick = link.divTick;
    assign activeDivide = link.activeSelect;

    ////////////////////////////////////////////////////////////////////////////////
    // Core control register

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleepAllow_q <= 1'b0;
            sleepKind_q  <= SLEEP_IDLE;
        end else if (wrCore) begin
            sleepAllow_q <= regWdata[`SLEEP_ALLOW_BIT];
            sleepKind_q  <= sleep_kind_t'(regWdata[`SLEEP_KIND_MSB:`SLEEP_KIND_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wake source selection

    always_comb begin
        unique case (activeKind_q)
            SLEEP_IDLE: begin
                wakeEvent = anyIrq || externalEdgeIrq || externalLevelIrq
                         || pinChangeIrq || watchdogIrq || converterDoneIrq
                         || memoryReadyIrq;
            end
            SLEEP_NOISE_RED: begin
                wakeEvent = converterDoneIrq || memoryReadyIrq || externalLevelIrq
                         || pinChangeIrq || watchdogIrq;
            end
            SLEEP_POWERDOWN: begin
                wakeEvent = externalLevelIrq || pinChangeIrq
                         || watchdogIrq;
            end
            SLEEP_STANDBY: begin
                wakeEvent = externalLevelIrq || pinChangeIrq
                         || watchdogIrq;
            end
        endcase
    end

    // Standby needs an external crystal; otherwise the code falls back to power-down
    assign oscStopped = (activeKind_q == SLEEP_POWERDOWN)
                     || ((activeKind_q == SLEEP_STANDBY) && !crystalSource);

    assign sleepTaken = sleepInstr && sleepAllow_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep state machine

    always_comb begin
        state_d   = state_q;
        waitCnt_d = waitCnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (sleepTaken) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeEvent) begin
                    if (oscStopped) begin
                        state_d   = ST_STARTUP;
                        waitCnt_d = STARTUP_CYCLES;
                    end else if (activeKind_q == SLEEP_STANDBY) begin
                        state_d   = ST_STARTUP;
                        waitCnt_d = `STANDBY_WAKE_CYCLES;
                    end else begin
                        state_d   = ST_HALT;
                        waitCnt_d = `WAKE_HALT_CYCLES;
                    end
                end
            end
            ST_STARTUP: begin
                if (waitCnt_q <= 16'h0001) begin
                    state_d   = ST_HALT;
                    waitCnt_d = `WAKE_HALT_CYCLES;
                end else begin
                    waitCnt_d = waitCnt_q - 16'h0001;
                end
            end
            ST_HALT: begin
                if (waitCnt_q <= 16'h0001) begin
                    state_d   = ST_RUN;
                    waitCnt_d = 16'h0000;
                end else begin
                    waitCnt_d = waitCnt_q - 16'h0001;
                end
            end
        endcase
    end

    // Sleep never touches stored registers; only rstn leaves sleep by reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ST_RUN;
            waitCnt_q <= 16'h0000;
        end else begin
            state_q   <= state_d;
            waitCnt_q <= waitCnt_d;
        end
    end

    // Mode is latched at entry so later register writes cannot alter it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            activeKind_q <= SLEEP_IDLE;
        end else if ((state_q == ST_RUN) && sleepTaken) begin
            activeKind_q <= sleepKind_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Entry and exit pulses

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            startConv_q <= 1'b0;
            resume_q    <= 1'b0;
        end else begin
            startConv_q <= (state_q == ST_RUN) && sleepTaken && converterEnabled
                        && ((sleepKind_q == SLEEP_IDLE)
                            || (sleepKind_q == SLEEP_NOISE_RED));
            resume_q    <= (state_q == ST_HALT) && (state_d == ST_RUN);
        end
    end

    assign startConversion = startConv_q;
    assign resumeCore      = resume_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock domain gating

    always_comb begin
        coreClockRun          = (state_q == ST_RUN);
        programMemoryClockRun = (state_q == ST_RUN);
        peripheralClockRun    = 1'b1;
        converterClockRun     = 1'b1;
        oscillatorRun         = 1'b1;
        coreHalted            = (state_q != ST_RUN);
        if (state_q == ST_SLEEP) begin
            unique case (activeKind_q)
                SLEEP_IDLE: begin
                    peripheralClockRun = 1'b1;
                end
                SLEEP_NOISE_RED: begin
                    peripheralClockRun = 1'b0;
                end
                SLEEP_POWERDOWN: begin
                    peripheralClockRun = 1'b0;
                    converterClockRun  = 1'b0;
                    oscillatorRun      = 1'b0;
                end
                SLEEP_STANDBY: begin
                    peripheralClockRun = 1'b0;
                    converterClockRun  = 1'b0;
                    oscillatorRun      = crystalSource;
                end
            endcase
        end else if (state_q == ST_STARTUP) begin
            peripheralClockRun = 1'b0;
            converterClockRun  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `READ_IDLE;
        end else if (regRead) begin
            unique case (regAddr)
                `ADDR_OSC_TRIM: begin
                    rdata_q <= trim_q;
                end
                `ADDR_DIVIDE_CONTROL: begin
                    rdata_q <= {unlockOpen, 3'h0, select_q};
                end
                `ADDR_CORE_CONTROL: begin
                    rdata_q <= {2'h0, sleepAllow_q, sleepKind_q, 3'h0};
                end
                `ADDR_SLEEP_STATUS: begin
                    rdata_q <= {2'h0, state_q, link.activeSelect};
                end
                default: begin
                    rdata_q <= `READ_IDLE;
                end
            endcase
        end else begin
            rdata_q <= `READ_IDLE;
        end
    end

    assign regRdata = rdata_q;

endmodule

`default_nettype wire

// ==== testbench/clock_sleep_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "clock_sleep_defs.svh"

module clock_sleep_chk
    import clock_sleep_pkg::*;
(
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] factoryTrim,
    input wire logic       sleepInstr,
    input wire logic       converterEnabled,
    input wire logic [7:0] oscTrim,
    input wire logic       trimRangeSelect,
    input wire logic [6:0] trimFine,
    input wire logic       coreClockRun,
    input wire logic       programMemoryClockRun,
    input wire logic       peripheralClockRun,
    input wire logic       converterClockRun,
    input wire logic       oscillatorRun,
    input wire logic       coreHalted,
    input wire logic       startConversion,
    input wire logic       resumeCore
);
    logic        allowQ;
    sleep_kind_t kindQ;

    // Mirror of the sleep control bits, so entry can be judged from the bus alone
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            allowQ <= 1'b0;
            kindQ  <= SLEEP_IDLE;
        end else if (regWrite && regAddr == `ADDR_CORE_CONTROL) begin
            allowQ <= regWdata[`SLEEP_ALLOW_BIT];
            kindQ  <= sleep_kind_t'(regWdata[`SLEEP_KIND_MSB:`SLEEP_KIND_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence sEnter;
        sleepInstr && !coreHalted && allowQ;
    endsequence

    AST_TRIM_LOAD: assert property ($rose(rstn) |=> oscTrim == $past(factoryTrim))
        else $error("trim not loaded from factory value");
    AST_TRIM_SPLIT: assert property (trimRangeSelect == oscTrim[7] && trimFine == oscTrim[6:0])
        else $error("trim fields differ from trim register");
    AST_RSV_ZERO: assert property (regRead && regAddr == `ADDR_DIVIDE_CONTROL |=> regRdata[6:4] == 3'h0)
        else $error("reserved divide bits not zero");
    AST_NOOP: assert property (sleepInstr && !coreHalted && !allowQ |=> !coreHalted && coreClockRun)
        else $error("sleep taken while not allowed");
    AST_ENTER: assert property (sEnter |=> coreHalted && !coreClockRun)
        else $error("allowed sleep not entered");
    AST_IDLE_CLK: assert property (sEnter ##0 kindQ == SLEEP_IDLE |=> !programMemoryClockRun && peripheralClockRun && converterClockRun && oscillatorRun)
        else $error("idle clock gating wrong");
    AST_NOISE_CLK: assert property (sEnter ##0 kindQ == SLEEP_NOISE_RED |=> !peripheralClockRun && !programMemoryClockRun && converterClockRun)
        else $error("noise mode clock gating wrong");
    AST_PDOWN_CLK: assert property (sEnter ##0 kindQ == SLEEP_POWERDOWN |=> !oscillatorRun && !converterClockRun && !peripheralClockRun)
        else $error("power-down clock gating wrong");
    AST_AUTO_CONV: assert property (sEnter ##0 converterEnabled && !kindQ[1] |=> startConversion)
        else $error("conversion not started on sleep entry");
    AST_RESUME: assert property ($fell(coreHalted) |-> resumeCore && $past(coreHalted, 4))
        else $error("resume without four halted cycles");
endmodule

bind clock_prescale_sleep_control clock_sleep_chk u_chk (.clock, .rstn, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .factoryTrim, .sleepInstr, .converterEnabled, .oscTrim,
    .trimRangeSelect, .trimFine, .coreClockRun, .programMemoryClockRun, .peripheralClockRun,
    .converterClockRun, .oscillatorRun, .coreHalted, .startConversion, .resumeCore);

`default_nettype wire

// ==== testbench/core_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module core_model (
    input  wire logic       clock,
    input  wire logic [7:0] regRdata,
    output logic      [3:0] regAddr,
    output logic      [7:0] regWdata,
    output logic            regWrite,
    output logic            regRead,
    output logic            sleepInstr
);
    initial begin
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        sleepInstr = 1'b0;
    end

    // No memory writes are issued here, so any trim value is safe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Select lands on the last cycle of the window; no interrupt can split the pair
    task automatic div_change(input logic [3:0] code);
        wr(4'h1, 8'h80);
        repeat (2) @(posedge clock);
        wr(4'h1, {4'h0, code});
    endtask

    task automatic sleep_op();
        @(posedge clock);
        sleepInstr <= 1'b1;
        @(posedge clock);
        sleepInstr <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import clock_sleep_pkg::*;
    localparam logic [15:0] STARTUP = 16'h0002;
    logic clock, rstn, fuse, crystal, convEn;
    logic [7:0] factory;
    logic [6:0] irq;
    wire logic [7:0] regRdata, oscTrim, regWdata;
    wire logic [6:0] trimFine;
    wire logic [3:0] activeDivide, regAddr;
    wire logic regWrite, regRead, sleepInstr, trimRangeSelect, sysClockTick, coreHalted;
    int errors, n_checks;

    core_model core (.clock(clock), .regRdata(regRdata), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .sleepInstr(sleepInstr));

    clock_prescale_sleep_control #(.STARTUP_CYCLES(STARTUP)) dut (.clock(clock), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .factoryTrim(factory), .divideByEightFuse(fuse),
        .crystalSource(crystal), .sleepInstr(sleepInstr), .converterEnabled(convEn),
        .anyIrq(irq[6]), .converterDoneIrq(irq[5]), .memoryReadyIrq(irq[4]),
        .externalLevelIrq(irq[3]), .externalEdgeIrq(irq[2]), .pinChangeIrq(irq[1]),
        .watchdogIrq(irq[0]), .oscTrim(oscTrim), .trimRangeSelect(trimRangeSelect),
        .trimFine(trimFine), .sysClockTick(sysClockTick), .activeDivide(activeDivide),
        .coreClockRun(), .programMemoryClockRun(), .peripheralClockRun(),
        .converterClockRun(), .oscillatorRun(), .coreHalted(coreHalted),
        .startConversion(), .resumeCore());

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        core.rd(a, d);
        chk(name, exp, d);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_trim();
        rdchk(4'h0, 8'h60, "trim reset");
        rdchk(4'h1, 8'h03, "divide reset");
        rdchk(4'hf, 8'h00, "unmapped");
        core.wr(4'h0, 8'h7f);
        rdchk(4'h0, 8'h7f, "trim");
        chk("fine", 8'h7f, {1'b0, trimFine});
        chk("range low", 8'h00, {7'h0, trimRangeSelect});
        core.wr(4'h0, 8'h80);
        #1;
        chk("range high", 8'h01, {7'h0, trimRangeSelect});
    endtask

    task automatic t_unlock();
        core.wr(4'h1, 8'h81);
        core.wr(4'h1, 8'h02);
        rdchk(4'h1, 8'h03, "unlock with bits");
        core.wr(4'h1, 8'h80);
        rdchk(4'h1, 8'h83, "window open");
        @(posedge clock);
        rdchk(4'h1, 8'h03, "window timeout");
        core.wr(4'h1, 8'h80);
        core.wr(4'h1, 8'h80);
        @(posedge clock);
        core.wr(4'h1, 8'h07);
        rdchk(4'h1, 8'h03, "rewrite window");
        core.wr(4'h1, 8'h80);
        core.wr(4'h1, 8'h05);
        rdchk(4'h1, 8'h05, "select write");
    endtask

    task automatic t_divide();
        logic [3:0] codes[3] = '{4'h8, 4'h2, 4'h0};
        int n;
        foreach (codes[i]) begin
            core.div_change(codes[i]);
            n = 0;
            while (activeDivide !== codes[i] && n < 600) begin
                @(posedge clock);
                #1;
                n++;
            end
            chk("active divide", {4'h0, codes[i]}, {4'h0, activeDivide});
            // Tick is combinational, so look at it only once the edge has settled
            do begin
                @(posedge clock);
                #1;
            end while (!sysClockTick);
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (!sysClockTick && n < 300);
            chk("tick period", 8'((1 << codes[i]) >> 1), n[8:1]);
            chk("tick period lsb", {7'h0, codes[i] == 4'h0}, {7'h0, n[0]});
        end
    endtask

    task automatic sleep_case(input logic [1:0] m, input logic [6:0] bad, input logic [6:0] good,
                              input int exp);
        int n;
        core.wr(4'h2, {2'b00, 1'b1, m, 3'b000});
        core.sleep_op();
        #1;
        chk("asleep", 8'h01, {7'h0, coreHalted});
        @(posedge clock);
        irq <= bad;
        repeat (12) @(posedge clock);
        #1;
        chk("no wake", 8'h01, {7'h0, coreHalted});
        @(posedge clock);
        irq <= good;
        @(posedge clock);
        irq <= 7'h00;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (coreHalted && n < 40);
        // n counts the edges from wake to run, which equals the halted cycles
        chk("halt cycles", 8'(exp), 8'(n));
    endtask

    task automatic t_sleep();
        core.wr(4'h2, 8'h00);
        core.sleep_op();
        #1;
        chk("no-op sleep", 8'h00, {7'h0, coreHalted});
        @(posedge clock);
        convEn <= 1'b1;
        crystal <= 1'b1;
        sleep_case(2'b00, 7'h00, 7'h40, 4);
        sleep_case(2'b01, 7'h44, 7'h10, 4);
        sleep_case(2'b10, 7'h74, 7'h08, int'(STARTUP) + 4);
        sleep_case(2'b11, 7'h74, 7'h01, 10);
        rdchk(4'h0, 8'h80, "trim kept");
        core.wr(4'h2, 8'h20);
        core.sleep_op();
        #1;
        chk("asleep before reset", 8'h01, {7'h0, coreHalted});
        @(posedge clock);
        fuse <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chk("reset wakes", 8'h00, {7'h0, coreHalted});
        repeat (2) @(posedge clock);
        rdchk(4'h0, 8'h60, "trim reload");
        rdchk(4'h1, 8'h00, "divide no fuse");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #(40 * 20000);
        errors++;
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        fuse = 1'b1;
        crystal = 1'b0;
        convEn = 1'b0;
        factory = 8'h60;
        irq = 7'h00;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        t_trim();
        t_unlock();
        t_divide();
        t_sleep();
        tally_and_finish();
    end
endmodule

`default_nettype wire
